// *** rtl/ecr_pkg.sv ***
package ecr_pkg;

    // Fabric size
    localparam int ECR_NUM_CH   = 8;
    localparam int ECR_NUM_GEN  = 49;
    localparam int ECR_NUM_USR  = 23;
    localparam int ECR_NUM_SYNC = 4;
    localparam int ECR_ADDR_W   = 12;
    localparam int ECR_IDX_W    = 10;

    // Channel path selection; the fourth code acts as asynchronous
    typedef enum logic [1:0] {
        ECR_PATH_SYNC,
        ECR_PATH_RESYNC,
        ECR_PATH_ASYNC
    } ecr_path_t;

    // Register indices, byte address is four times the index
    localparam logic [9:0] ECR_IDX_PEND    = 10'h004;
    localparam logic [9:0] ECR_IDX_FLAGS   = 10'h005;
    localparam logic [9:0] ECR_IDX_MASK    = 10'h006;
    localparam logic [9:0] ECR_IDX_PRICTL  = 10'h008;
    localparam logic [9:0] ECR_IDX_CHATTR  = 10'h009;
    localparam logic [9:0] ECR_IDX_USRATTR = 10'h00A;
    localparam logic [9:0] ECR_IDX_CHCFG0  = 10'h020;
    localparam logic [9:0] ECR_IDX_CHSTAT0 = 10'h027;
    localparam logic [9:0] ECR_IDX_STRIDE  = 10'h008;
    localparam logic [9:0] ECR_IDX_USRCFG0 = 10'h060;

    // Field positions
    localparam int ECR_ROUND_ROBIN_ENABLE_BIT     = 7;
    localparam int ECR_PATH_LSB     = 8;
    localparam int ECR_PEND_OVR_BIT = 8;
    localparam int ECR_PEND_EVD_BIT = 9;
    localparam int ECR_PEND_BSY_BIT = 15;
    localparam int ECR_FLAG_OVR_LSB = 8;

    // Values after reset
    localparam logic [7:0]  ECR_PRICTL_RST = 8'h00;
    localparam logic [7:0]  ECR_CHSTAT_RST = 8'h01;
    localparam logic [15:0] ECR_FLAGS_RST  = 16'h0000;
    localparam logic [7:0]  ECR_ATTR_RST   = 8'h00;
    localparam ecr_path_t   ECR_PATH_RST   = ECR_PATH_SYNC;

    // AXI responses
    localparam logic [1:0] ECR_RESP_OKAY   = 2'b00;
    localparam logic [1:0] ECR_RESP_SLVERR = 2'b10;
    localparam logic [1:0] ECR_RESP_DECERR = 2'b11;

endpackage : ecr_pkg

// *** rtl/ecr_event_router.sv ***
// Chosen here: the AXI4-Lite interface to the registers.
module ecr_event_router #(
    parameter int NUM_GEN = ecr_pkg::ECR_NUM_GEN,
    parameter int NUM_USR = ecr_pkg::ECR_NUM_USR
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          ce,
    input  wire logic [ecr_pkg::ECR_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                    awprot,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [ecr_pkg::ECR_ADDR_W-1:0] araddr,
    input  wire logic [2:0]                    arprot,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire logic [NUM_GEN-1:0]            gen_event,
    input  wire logic [NUM_USR-1:0]            user_ready,
    input  wire logic [NUM_USR-1:0]            user_ack,
    input  wire logic [ecr_pkg::ECR_NUM_SYNC-1:0] channel_generic_clock,
    output logic [NUM_USR-1:0]                 user_event,
    output logic                               irq
);
    import ecr_pkg::*;

    localparam int NC = ECR_NUM_CH;

    // Selector fields are six and four bits wide
    if (NUM_GEN < 1 || NUM_GEN > 63) begin : g_bad_gen
        $error("NUM_GEN must be 1 to 63");
    end
    if (NUM_USR < 1 || NUM_USR > 32) begin : g_bad_usr
        $error("NUM_USR must be 1 to 32");
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Arbitration: lowest channel first, rotation over 0..3 after the pointer
    function automatic logic [3:0] ecr_arbitrate(input logic [7:0] req, input logic rr,
                                                 input logic [1:0] ptr);
        logic [3:0] res;
        logic [1:0] k;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) res = {1'b1, 3'(i)};
        end
        if (rr) begin
            for (int j = 4; j >= 1; j--) begin
                k = ptr + 2'(j);
                if (req[k]) res = {2'b10, k};
            end
        end
        return res;
    endfunction : ecr_arbitrate

    logic                  aw_held_q, w_held_q, aw_ns_q;
    logic [ECR_ADDR_W-1:0] awaddr_q;
    logic [31:0]           wdata_q, rdata_q;
    logic [3:0]            wstrb_q;
    logic                  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]            bresp_q, rresp_q;
    logic                  round_robin_enable_q;
    logic [1:0]            pri_q;
    logic [15:0]           flags_q, mask_q;
    logic [NC-1:0]         chattr_q;
    logic [NUM_USR-1:0]    usrattr_q;
    logic [5:0]            gsel_q [NC];
    ecr_path_t             path_q [NC];
    logic [3:0]            usel_q [NUM_USR];
    logic [NUM_USR-1:0]    user_event_q;
    logic                  irq_q;
    logic [NC-1:0]         sel_evt_q;

    // Bus handshake decode
    wire do_wr     = aw_held_q & w_held_q & ~bvalid_q;
    wire aw_take   = awvalid & awready_q;
    wire w_take    = wvalid & wready_q;
    wire ar_take   = arvalid & arready_q;
    wire aw_held_d = ~do_wr & (aw_held_q | aw_take);
    wire w_held_d  = ~do_wr & (w_held_q | w_take);
    wire rvalid_d  = ar_take | (rvalid_q & ~rready);
    wire [9:0]  widx = awaddr_q[11:2];
    wire [9:0]  ridx = araddr[11:2];
    wire        r_ns = arprot[1];
    wire [31:0] wm   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wd   = wdata_q & wm;

    // Fixed register write decode; security registers refuse non-secure writers
    wire hit_pend    = widx == ECR_IDX_PEND;
    wire hit_flags   = widx == ECR_IDX_FLAGS;
    wire hit_mask    = widx == ECR_IDX_MASK;
    wire hit_pri     = widx == ECR_IDX_PRICTL;
    wire hit_chattr  = widx == ECR_IDX_CHATTR;
    wire hit_usrattr = widx == ECR_IDX_USRATTR;
    wire we_pend     = do_wr & hit_pend;
    wire we_flags    = do_wr & hit_flags;
    wire we_mask     = do_wr & hit_mask;
    wire we_pri      = do_wr & hit_pri & ~aw_ns_q;
    wire we_chattr   = do_wr & hit_chattr & ~aw_ns_q;
    wire we_usrattr  = do_wr & hit_usrattr & ~aw_ns_q;
    wire [15:0] ns_ok = aw_ns_q ? {chattr_q, chattr_q} : 16'hFFFF;

    logic [NC-1:0]      ch_hit, we_chcfg, sel_evt, trig, ch_async, ch_out;
    logic [NC-1:0]      busy_w, rdy_w, ovr_set;
    logic [NUM_USR-1:0] usr_hit, we_usr;
    logic [NUM_USR-1:0] conn_w [NC];
    logic [7:0]         status_w [NC];
    wire  [NUM_GEN:0]   gen_ext = {gen_event, 1'b0};
    wire  [NC:0]        ch_ext  = {ch_out, 1'b0};

    wire wr_denied = aw_ns_q & (hit_pri | hit_chattr | hit_usrattr
                   | |(ch_hit & ~chattr_q) | |(usr_hit & ~usrattr_q));
    wire wr_mapped = hit_pend | hit_flags | hit_mask | hit_pri | hit_chattr | hit_usrattr
                   | |ch_hit | |usr_hit;

    // Per-channel routing
    for (genvar c = 0; c < NC; c++) begin : g_ch
        assign ch_hit[c]   = widx == 10'(ECR_IDX_CHCFG0 + c * ECR_IDX_STRIDE);
        assign we_chcfg[c] = do_wr & ch_hit[c] & (~aw_ns_q | chattr_q[c]);
        // Any channel reaches any generator; code zero or past range is none
        assign sel_evt[c]  = (gsel_q[c] <= 6'(NUM_GEN)) & gen_ext[gsel_q[c]];
        assign ch_async[c] = (c >= ECR_NUM_SYNC)
                           | ((path_q[c] != ECR_PATH_SYNC) && (path_q[c] != ECR_PATH_RESYNC));
        assign trig[c]     = (path_q[c] == ECR_PATH_RESYNC) ? sel_evt[c] & ~sel_evt_q[c]
                                                            : sel_evt[c];
        // Vacuously ready when no user listens
        assign rdy_w[c]    = &(~conn_w[c] | user_ready);
        assign status_w[c] = {6'h00, busy_w[c] & ~ch_async[c], rdy_w[c] & ~ch_async[c]};

        if (c < ECR_NUM_SYNC) begin : g_sync
            logic               gs1_q, gs2_q, gs3_q, pend_q;
            logic [NUM_USR-1:0] ack_wait_q;
            wire tick = gs2_q & ~gs3_q;
            wire fire = tick & pend_q & ~ch_async[c];
            // Rising channel clock edges move the held event out, one aclk pulse
            assign ch_out[c]  = ch_async[c] ? sel_evt[c] : fire;
            // A held event counts as unhandled until every user selecting the channel when it fired has acknowledged it
            assign busy_w[c]  = pend_q | (|ack_wait_q);
            assign ovr_set[c] = trig[c] & ~ch_async[c] & (pend_q | busy_w[c]);
            // Channel clock is foreign: two stages before the edge detector
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    gs1_q      <= 1'b0;
                    gs2_q      <= 1'b0;
                    gs3_q      <= 1'b0;
                    pend_q     <= 1'b0;
                    ack_wait_q <= '0;
                end else if (ce) begin
                    gs1_q      <= channel_generic_clock[c];
                    gs2_q      <= gs1_q;
                    gs3_q      <= gs2_q;
                    pend_q     <= (pend_q & ~fire) | (trig[c] & ~ch_async[c]);
                    ack_wait_q <= fire ? conn_w[c] : ack_wait_q & ~user_ack;
                end
            end
        end else begin : g_async
            assign ch_out[c]  = sel_evt[c];
            assign busy_w[c]  = 1'b0;
            assign ovr_set[c] = 1'b0;
        end
    end

    // Per-user channel choice
    for (genvar u = 0; u < NUM_USR; u++) begin : g_usr
        assign usr_hit[u] = widx == 10'(ECR_IDX_USRCFG0 + u);
        assign we_usr[u]  = do_wr & usr_hit[u] & (~aw_ns_q | usrattr_q[u]);
        for (genvar c = 0; c < NC; c++) begin : g_conn
            assign conn_w[c][u] = usel_q[u] == 4'(c + 1);
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                usel_q[u]       <= 4'h0;
                user_event_q[u] <= 1'b0;
            end else if (ce) begin
                if (we_usr[u]) usel_q[u] <= wd[3:0];
                user_event_q[u] <= (usel_q[u] <= 4'(NC)) & ch_ext[usel_q[u]];
            end
        end
    end

    // Channel configuration registers
    for (genvar c = 0; c < NC; c++) begin : g_cfg
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gsel_q[c]    <= 6'h00;
                path_q[c]    <= ECR_PATH_RST;
                sel_evt_q[c] <= 1'b0;
            end else if (ce) begin
                sel_evt_q[c] <= sel_evt[c];
                if (we_chcfg[c]) begin
                    gsel_q[c] <= wd[5:0];
                    path_q[c] <= ecr_path_t'(wd[ECR_PATH_LSB +: 2]);
                end
            end
        end
    end

    // Interrupt arbitration over per-channel unmasked flags
    wire [7:0] req     = (flags_q[7:0] & mask_q[7:0])
                       | (flags_q[15:8] & mask_q[15:8]);
    wire [3:0] grant   = ecr_arbitrate(req, round_robin_enable_q, pri_q);
    wire [2:0] gid     = grant[2:0];
    wire       g_ok    = grant[3] & (~aw_ns_q | chattr_q[gid]);
    wire [7:0] g_onehot = 8'h01 << gid;
    wire [15:0] clr_pend = (we_pend & g_ok)
                         ? {wd[ECR_PEND_OVR_BIT] ? g_onehot : 8'h00,
                            wd[ECR_PEND_EVD_BIT] ? g_onehot : 8'h00} : 16'h0000;
    wire [15:0] clr_flag = we_flags ? (wd[15:0] & ns_ok) : 16'h0000;
    wire [15:0] set_flag = {ovr_set, ch_out};
    // Set is ORed last so a same-cycle event survives its clear
    wire [15:0] flags_d  = (flags_q & ~(clr_pend | clr_flag)) | set_flag;
    wire        upd_pri  = (we_pend | we_flags) & round_robin_enable_q & grant[3] & ~gid[2];

    // Arbitration and interrupt state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            round_robin_enable_q    <= ECR_PRICTL_RST[ECR_ROUND_ROBIN_ENABLE_BIT];
            pri_q     <= ECR_PRICTL_RST[1:0];
            flags_q   <= ECR_FLAGS_RST;
            mask_q    <= ECR_FLAGS_RST;
            chattr_q  <= ECR_ATTR_RST;
            usrattr_q <= '0;
            irq_q     <= 1'b0;
        end else if (ce) begin
            flags_q <= flags_d;
            irq_q   <= |(flags_q & mask_q);
            if (we_mask) mask_q <= (mask_q & ~(wm[15:0] & ns_ok)) | (wd[15:0] & ns_ok);
            if (we_chattr) chattr_q <= wd[7:0];
            if (we_usrattr) usrattr_q <= wd[NUM_USR-1:0];
            if (we_pri) begin
                round_robin_enable_q <= wd[ECR_ROUND_ROBIN_ENABLE_BIT];
                // Pointer kept when round-robin is switched off
                if (wd[ECR_ROUND_ROBIN_ENABLE_BIT]) pri_q <= wd[1:0];
            end else if (upd_pri) begin
                pri_q <= gid[1:0];
            end
        end
    end

    // Read selection
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = ECR_RESP_DECERR;
        unique case (ridx)
            ECR_IDX_PEND: begin
                rd_resp = ECR_RESP_OKAY;
                rd_data[2:0] = gid;
                rd_data[ECR_PEND_OVR_BIT] = grant[3] & flags_q[ECR_FLAG_OVR_LSB + 32'(gid)];
                rd_data[ECR_PEND_EVD_BIT] = grant[3] & flags_q[gid];
                rd_data[ECR_PEND_BSY_BIT] = busy_w[gid];
            end
            ECR_IDX_FLAGS:   begin rd_resp = ECR_RESP_OKAY; rd_data[15:0] = flags_q; end
            ECR_IDX_MASK:    begin rd_resp = ECR_RESP_OKAY; rd_data[15:0] = mask_q;  end
            ECR_IDX_PRICTL: begin
                rd_resp = ECR_RESP_OKAY;
                rd_data[ECR_ROUND_ROBIN_ENABLE_BIT] = round_robin_enable_q;
                rd_data[1:0] = pri_q;
            end
            ECR_IDX_CHATTR:  begin rd_resp = ECR_RESP_OKAY; rd_data[7:0] = chattr_q; end
            ECR_IDX_USRATTR: begin rd_resp = ECR_RESP_OKAY; rd_data[NUM_USR-1:0] = usrattr_q; end
            default: ;
        endcase
        for (int c = 0; c < NC; c++) begin
            if (ridx == 10'(ECR_IDX_CHCFG0 + c * ECR_IDX_STRIDE)) begin
                rd_resp = ECR_RESP_OKAY;
                rd_data[5:0] = gsel_q[c];
                rd_data[ECR_PATH_LSB +: 2] = path_q[c];
            end
            if (ridx == 10'(ECR_IDX_CHSTAT0 + c * ECR_IDX_STRIDE)) begin
                // Secure channel hidden from non-secure readers
                rd_resp = (r_ns & ~chattr_q[c]) ? ECR_RESP_SLVERR : ECR_RESP_OKAY;
                rd_data[7:0] = (r_ns & ~chattr_q[c]) ? 8'h00 : status_w[c];
            end
        end
        for (int u = 0; u < NUM_USR; u++) begin
            if (ridx == 10'(ECR_IDX_USRCFG0 + u)) begin
                rd_resp = ECR_RESP_OKAY;
                rd_data[3:0] = usel_q[u];
            end
        end
    end

    // AXI4-Lite slave: one write and one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= ECR_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= ECR_RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
            awaddr_q  <= '0;
            aw_ns_q   <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else if (ce) begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awready_q <= ~aw_held_d;
            wready_q  <= ~w_held_d;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            if (aw_take) begin
                awaddr_q <= awaddr;
                aw_ns_q  <= awprot[1];
            end
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q  <= !wr_mapped ? ECR_RESP_DECERR
                          : wr_denied  ? ECR_RESP_SLVERR : ECR_RESP_OKAY;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
            if (ar_take) begin
                rdata_q <= rd_data;
                rresp_q <= rd_resp;
            end
        end
    end

    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign user_event = user_event_q;
    assign irq        = irq_q;

    // Checks
    property p_async_route;
        ce & ch_async[0] & sel_evt[0]
            |=> (user_event & $past(conn_w[0])) == $past(conn_w[0]);
    endproperty
    a_async_route: assert property (p_async_route) else $error("async event lost");
    property p_sync_on_tick;
        ce & ~ch_async[0] & ch_out[0] |-> g_ch[0].g_sync.tick ##1 user_event[0] || usel_q[0] != 4'h1;
    endproperty
    a_sync_on_tick: assert property (p_sync_on_tick) else $error("sync fire off tick");
    property p_user_select;
        ce & (usel_q[0] == 4'h0) |=> !user_event[0];
    endproperty
    a_user_select: assert property (p_user_select) else $error("unselected user hit");
    property p_static_order;
        !round_robin_enable_q & req[0] |-> grant == 4'h8;
    endproperty
    a_static_order: assert property (p_static_order) else $error("static order broken");
    property p_pri_update;
        ce & upd_pri |=> pri_q == $past(gid[1:0]);
    endproperty
    a_pri_update: assert property (p_pri_update) else $error("pointer not updated");
    property p_pri_keep;
        ce & we_pri & !wd[ECR_ROUND_ROBIN_ENABLE_BIT] |=> pri_q == $past(pri_q) && !round_robin_enable_q;
    endproperty
    a_pri_keep: assert property (p_pri_keep) else $error("pointer lost");
    property p_busy_set;
        ce & ch_out[0] & ~ch_async[0] & |conn_w[0] & ~|user_ack |=> busy_w[0];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set");
    property p_busy_async;
        ce & ar_take & ch_async[0] & (ridx == ECR_IDX_CHSTAT0) |=> !rdata[1];
    endproperty
    a_busy_async: assert property (p_busy_async) else $error("busy on async path");
    property p_ready;
        ce & ar_take & ~ch_async[0] & (ridx == ECR_IDX_CHSTAT0) & |(conn_w[0] & ~user_ready)
            |=> !rdata[0];
    endproperty
    a_ready: assert property (p_ready) else $error("ready wrong");
    property p_ready_async;
        ce & ar_take & ch_async[0] & (ridx == ECR_IDX_CHSTAT0) |=> !rdata[0];
    endproperty
    a_ready_async: assert property (p_ready_async) else $error("ready on async path");
    property p_ns_status;
        ce & ar_take & r_ns & !chattr_q[0] & (ridx == ECR_IDX_CHSTAT0)
            |=> rdata == 32'h0000_0000 && rresp == ECR_RESP_SLVERR && rvalid;
    endproperty
    a_ns_status: assert property (p_ns_status) else $error("secure status leaked");
    property p_stat_reset;
        $past(!aresetn) |-> status_w[0] == ECR_CHSTAT_RST;
    endproperty
    a_stat_reset: assert property (p_stat_reset) else $error("status reset wrong");
    c_sync_fire:  cover property (ce & ~ch_async[0] & ch_out[0]);
    c_rr_grant:   cover property (ce & upd_pri);
    c_irq:        cover property (irq);
    c_ns_denied:  cover property (do_wr & wr_denied);

endmodule : ecr_event_router

// *** tb/ecr_partner.sv ***
// Generators and users on the far side of the router
module ecr_partner (
    input  wire logic        aclk,
    input  wire logic        fire,
    input  wire logic [5:0]  gen_idx,
    input  wire logic [22:0] user_event,
    input  wire logic [22:0] stall,
    output logic      [48:0] gen_event,
    output logic      [22:0] user_ready,
    output logic      [22:0] user_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle pulse per request, index 1..49
    always_ff @(posedge aclk) begin
        gen_event <= fire ? (49'(1) << (gen_idx - 6'd1)) : '0;
    end
    // Users ready unless stalled; ack one cycle late, so busy can drain
    always_ff @(posedge aclk) begin
        user_ready <= ~stall;
        user_ack   <= user_event;
    end
endmodule : ecr_partner

// *** tb/testbench.sv ***
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ecr_pkg::*;
    logic        aclk, aresetn, fire, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [5:0]  gen_idx;
    logic [48:0] gen_event;
    logic [22:0] user_ready, user_ack, user_event, stall;
    logic [3:0]  gclk;
    int          fail_count, n_tests, g, u, v, gi;
    int          usr_sel[23];
    int          ch_gen[8];

    ecr_event_router DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
        .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .gen_event(gen_event), .user_ready(user_ready), .user_ack(user_ack),
        .channel_generic_clock(gclk), .user_event(user_event), .irq(irq));
    ecr_partner far_side (.aclk(aclk), .fire(fire), .gen_idx(gen_idx),
        .user_event(user_event), .stall(stall), .gen_event(gen_event), .user_ready(user_ready),
        .user_ack(user_ack));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Verdict in one place, also reached by the watchdog
    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Write: offer both channels, drop each once taken, wait for response
    task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic ns);
        @(posedge aclk);
        awaddr  <= {i, 2'b00};
        awprot  <= {1'b0, ns, 1'b0};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [9:0] i, input logic ns);
        @(posedge aclk);
        araddr  <= {i, 2'b00};
        arprot  <= {1'b0, ns, 1'b0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    // One-cycle generator pulse; returns just after the edge that routes it
    task automatic pulse(input int gn);
        @(posedge aclk);
        fire    <= 1'b1;
        gen_idx <= 6'(gn);
        @(posedge aclk);
        fire    <= 1'b0;
        @(posedge aclk);
        #1;
    endtask : pulse

    // Model: users whose selected channel carries generator gi
    function automatic logic [22:0] exp_mask(int gi);
        exp_mask = '0;
        for (int k = 0; k < 23; k++)
            if (usr_sel[k] > 0 && ch_gen[usr_sel[k] - 1] == gi) exp_mask[k] = 1'b1;
    endfunction : exp_mask

    initial begin
        {aresetn, fire, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wdata, gen_idx, gclk, stall} = '0;
        g = $urandom(32'hc4c6ae8b);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int n = 0; n < 8; n++) begin
            rd_reg(10'(ECR_IDX_CHSTAT0 + n * ECR_IDX_STRIDE), 1'b0);
            `CHK("chstat", (n < 4) ? 8'h01 : 8'h00, rd[7:0])
        end
        // Pointer survives a write that clears round-robin
        wr(ECR_IDX_PRICTL, 32'h0000_0081, 1'b0);
        wr(ECR_IDX_PRICTL, 32'h0000_0000, 1'b0);
        rd_reg(ECR_IDX_PRICTL, 1'b0);
        `CHK("prictl", 8'h01, rd[7:0])
        wr(ECR_IDX_PRICTL, 32'h0000_0080, 1'b1);
        `CHK("ns_wr", ECR_RESP_SLVERR, rs)
        rd_reg(10'h3FF, 1'b0);
        `CHK("unmapped", ECR_RESP_DECERR, rs)
        // Random generator and user on channel 0, a neighbour on channel 3
        g = $urandom_range(49, 1);
        gi = (g % 49) + 1;
        u = $urandom_range(22, 0);
        v = (u + 1) % 23;
        ch_gen[0] = g;
        ch_gen[3] = gi;
        usr_sel[u] = 1;
        usr_sel[v] = 4;
        wr(ECR_IDX_CHCFG0, 32'h0000_0200 | 32'(g), 1'b0);
        wr(10'(ECR_IDX_CHCFG0 + 3 * ECR_IDX_STRIDE), 32'h0000_0200 | 32'(gi), 1'b0);
        wr(10'(ECR_IDX_USRCFG0 + u), 32'h0000_0001, 1'b0);
        wr(10'(ECR_IDX_USRCFG0 + v), 32'h0000_0004, 1'b0);
        rd_reg(ECR_IDX_CHSTAT0, 1'b0);
        `CHK("async_stat", 8'h00, rd[7:0])
        rd_reg(ECR_IDX_CHSTAT0, 1'b1);
        `CHK("ns_rd", ECR_RESP_SLVERR, rs)
        for (int k = 0; k < 2; k++) begin
            pulse((k == 0) ? g : gi);
            `CHK("user_event", exp_mask((k == 0) ? g : gi), user_event)
        end
        wr(ECR_IDX_MASK, 32'h0000_0001, 1'b0);
        @(posedge aclk);
        #1;
        `CHK("irq_on", 1'b1, irq)
        wr(ECR_IDX_FLAGS, 32'h0000_0001, 1'b0);
        @(posedge aclk);
        #1;
        `CHK("irq_off", 1'b0, irq)
        wr(ECR_IDX_CHATTR, 32'h0000_0001, 1'b0);
        rd_reg(ECR_IDX_CHSTAT0, 1'b1);
        `CHK("ns_ok", ECR_RESP_OKAY, rs)
        // Resync path: event held until the channel clock rises
        wr(ECR_IDX_CHCFG0, 32'h0000_0100 | 32'(g), 1'b0);
        pulse(g);
        `CHK("held", 23'h0, user_event)
        @(posedge aclk);
        stall <= 23'(1) << u;
        rd_reg(ECR_IDX_CHSTAT0, 1'b0);
        `CHK("busy_stall", 8'h02, rd[7:0])
        @(posedge aclk);
        stall <= '0;
        gclk  <= 4'h1;
        repeat (3) @(posedge aclk);
        #1;
        `CHK("sync_event", exp_mask(g), user_event)
        @(posedge aclk);
        gclk <= 4'h0;
        @(posedge aclk);
        rd_reg(ECR_IDX_CHSTAT0, 1'b0);
        `CHK("idle_stat", 8'h01, rd[7:0])
        // Static order despite a nonzero pointer, then rotation past it
        wr(ECR_IDX_MASK, 32'h0000_0009, 1'b0);
        rd_reg(ECR_IDX_PEND, 1'b0);
        `CHK("pend_static", 16'h0200, rd[15:0])
        wr(ECR_IDX_PRICTL, 32'h0000_0081, 1'b0);
        rd_reg(ECR_IDX_PEND, 1'b0);
        `CHK("pend_rr", 16'h0203, rd[15:0])
        wr(ECR_IDX_FLAGS, 32'h0000_0000, 1'b0);
        rd_reg(ECR_IDX_PRICTL, 1'b0);
        `CHK("pri_upd", 8'h83, rd[7:0])
        end_sim();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        end_sim();
    end
endmodule : testbench
